// [hdl/dsf_flag_cell.sv]
// Purpose: one sticky flag with hardware set, hardware clear and software write
// Assumes: synchronous active-high reset
// Notes: hardware set wins over every clear or write in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dsf_flag_cell (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic set_in,
  input wire logic clr_in,
  input wire logic wr_in,
  input wire logic wr_val_in,
  output logic q_out
);
  logic flag_d;

  assign flag_d = set_in ? 1'b1 : clr_in ? 1'b0 : wr_in ? wr_val_in : q_out;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      q_out <= 1'b0;
    end else begin
      q_out <= flag_d;
    end
  end
endmodule
`default_nettype wire

// [hdl/dsf_status_top.sv]
// Purpose: per-channel dma status flags, limit checks and interrupt, over axi4-lite
// Assumes: engine strobes are one-cycle pulses synchronous to core_clk_in
// Notes:
// Contract
// - buffered-write flag high until data written
// - flag access above upper limit or ram
// - flag access below lower, above sfr
// - completion flag: completed versus aborted session
// - halfway enable adds interrupt at halfway
// - flag trigger arriving while still busy
// - limits checked alongside access, never before
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
module dsf_status_top #(
  parameter logic [15:0] RAM_TOP = `DSF_RAM_TOP
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic access_valid_in,
  input wire logic [15:0] access_addr_in,
  input wire logic trigger_in,
  input wire logic busy_in,
  input wire logic half_in,
  input wire logic done_in,
  input wire logic abort_in,
  input wire logic buf_load_in,
  input wire logic buf_written_in,
  output logic channel_enable_out,
  output logic [5:0] trigger_source_select_out,
  output logic irq_out
);
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  dsf_pkg::dsf_flags_t flags_q, pend_q, mask_q;
  dsf_pkg::dsf_addr_t upper_q, lower_q;
  logic half_irq_en_q, bwp_q;

  // write path: address and data are caught independently, then applied together
  wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid_out;
  wire b_done = s_axi_bvalid_out & s_axi_bready_in;
  wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
  wire r_done = s_axi_rvalid_out & s_axi_rready_in;

  wire wr_int = do_wr & (awaddr_q == `DSF_OFF_INT);
  wire wr_pend = do_wr & (awaddr_q == `DSF_OFF_PEND);
  wire wr_mask = do_wr & (awaddr_q == `DSF_OFF_MASK);
  wire wr_upper = do_wr & (awaddr_q == `DSF_OFF_UPPER);
  wire wr_lower = do_wr & (awaddr_q == `DSF_OFF_LOWER);
  wire wr_ctrl = do_wr & (awaddr_q == `DSF_OFF_CTRL);
  wire wr_hit = wr_int | wr_pend | wr_mask | wr_upper | wr_lower | wr_ctrl;
  wire lo_lane = wstrb_q[0];
  wire hi_lane = wstrb_q[1];

  // limits are compared on the access strobe itself, so a violation is seen
  // with the access and cannot block it
  wire hi_ev = access_valid_in &
    ((access_addr_in > upper_q) | (access_addr_in > RAM_TOP));
  wire lo_ev = access_valid_in & (access_addr_in < lower_q) &
    (access_addr_in > `DSF_SFR_END);
  wire ovr_ev = trigger_in & busy_in;
  dsf_pkg::dsf_flags_t ev;
  assign ev = {hi_ev, lo_ev, done_in, half_in, ovr_ev};
  // halfway only interrupts when enabled; completion always does
  dsf_pkg::dsf_flags_t pend_set;
  assign pend_set = {ev[4:2], ev[1] & half_irq_en_q, ev[0]};

  // only hardware events reach the pending register, so software writes of
  // the status flags cannot request an interrupt
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      dsf_flag_cell u_flag (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .set_in(ev[gi]),
        .clr_in(gi == `DSF_IDX_DONE ? abort_in : 1'b0),
        .wr_in(wr_int & lo_lane),
        .wr_val_in(wdata_q[`DSF_FLAG_LSB + gi]),
        .q_out(flags_q[gi])
      );
      dsf_flag_cell u_pend (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .set_in(pend_set[gi]),
        .clr_in(1'b0),
        .wr_in(wr_pend & lo_lane & wdata_q[`DSF_FLAG_LSB + gi]),
        .wr_val_in(1'b0),
        .q_out(pend_q[gi])
      );
    end
  endgenerate

  wire [15:0] int_word = {bwp_q, 1'b0, trigger_source_select_out, flags_q,
    2'h0, half_irq_en_q};
  wire ar_int = (s_axi_araddr_in == `DSF_OFF_INT);
  wire ar_pend = (s_axi_araddr_in == `DSF_OFF_PEND);
  wire ar_mask = (s_axi_araddr_in == `DSF_OFF_MASK);
  wire ar_upper = (s_axi_araddr_in == `DSF_OFF_UPPER);
  wire ar_lower = (s_axi_araddr_in == `DSF_OFF_LOWER);
  wire ar_ctrl = (s_axi_araddr_in == `DSF_OFF_CTRL);
  wire ar_hit = ar_int | ar_pend | ar_mask | ar_upper | ar_lower | ar_ctrl;
  wire [15:0] rd_word = ar_int ? int_word :
    ar_pend ? {8'h00, pend_q, 3'h0} :
    ar_mask ? {8'h00, mask_q, 3'h0} :
    ar_upper ? upper_q :
    ar_lower ? lower_q :
    ar_ctrl ? {15'h0000, channel_enable_out} : 16'h0000;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `DSF_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? `DSF_RESP_OKAY : `DSF_RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid_out <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `DSF_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {16'h0000, rd_word};
      s_axi_rresp_out <= ar_hit ? `DSF_RESP_OKAY : `DSF_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mask_q <= 5'h00;
      upper_q <= `DSF_UPPER_RST;
      lower_q <= `DSF_LOWER_RST;
      half_irq_en_q <= 1'b0;
      channel_enable_out <= 1'b0;
      trigger_source_select_out <= 6'h00;
    end else begin
      if (wr_mask & lo_lane) mask_q <= wdata_q[`DSF_FLAG_MSB:`DSF_FLAG_LSB];
      if (wr_upper & lo_lane) upper_q[7:0] <= wdata_q[7:0];
      if (wr_upper & hi_lane) upper_q[15:8] <= wdata_q[15:8];
      if (wr_lower & lo_lane) lower_q[7:0] <= wdata_q[7:0];
      if (wr_lower & hi_lane) lower_q[15:8] <= wdata_q[15:8];
      if (wr_int & lo_lane) half_irq_en_q <= wdata_q[`DSF_BIT_HALF_IRQ_EN];
      if (wr_int & hi_lane) begin
        trigger_source_select_out <= wdata_q[`DSF_SEL_MSB:`DSF_SEL_LSB];
      end
      if (wr_ctrl & lo_lane) channel_enable_out <= wdata_q[`DSF_BIT_CH_ENABLE];
    end
  end

  // new buffered data wins over a write completing in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bwp_q <= 1'b0;
    end else if (buf_load_in) begin
      bwp_q <= 1'b1;
    end else if (buf_written_in) begin
      bwp_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(pend_q & mask_q);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_buf_clear: assert property (buf_written_in && !buf_load_in |=> !bwp_q)
    else $error("buffered write flag not cleared");
  a_high_set: assert property (access_valid_in && access_addr_in > RAM_TOP
    |=> flags_q[4] && pend_q[4])
    else $error("high limit flag missed");
  a_low_set: assert property (access_valid_in && access_addr_in < lower_q &&
    access_addr_in > `DSF_SFR_END |=> flags_q[3])
    else $error("low limit flag missed");
  a_done_abort: assert property (abort_in && !done_in |=> !flags_q[2])
    else $error("abort did not clear completion flag");
  a_half_gate: assert property (!half_irq_en_q && !pend_q[1] && !wr_int
    |=> !pend_q[1])
    else $error("halfway pending set while disabled");
  a_ovr_set: assert property (trigger_in && busy_in |=> flags_q[0] && pend_q[0])
    else $error("overrun not flagged");
  a_limit_cause: assert property ($rose(flags_q[4]) |->
    $past(access_valid_in) || $past(wr_int))
    else $error("high flag rose without access");
  a_sw_noirq: assert property (wr_int && ev == 5'h00 && pend_q == 5'h00
    |=> pend_q == 5'h00 ##1 !irq_out)
    else $error("software flag write raised interrupt");
  a_read_turn: assert property (ar_take |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");
  a_write_turn: assert property (do_wr |=> s_axi_bvalid_out)
    else $error("write response late");

  c_overrun: cover property (trigger_in && busy_in);
  c_half_irq: cover property (half_in && half_irq_en_q ##2 irq_out);
  c_bad_addr: cover property (s_axi_bvalid_out && s_axi_bresp_out == `DSF_RESP_SLVERR);
endmodule
`default_nettype wire

// [shared/dsf_defines.svh]
// Purpose: offsets, field positions and reset values of the channel status block
// Assumes: 32-bit register bus, one aligned word per register
// Notes: included by bare name
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

`define DSF_OFF_INT 8'h00
`define DSF_OFF_PEND 8'h04
`define DSF_OFF_MASK 8'h08
`define DSF_OFF_UPPER 8'h0c
`define DSF_OFF_LOWER 8'h10
`define DSF_OFF_CTRL 8'h14

`define DSF_BIT_BWP 15
`define DSF_SEL_LSB 8
`define DSF_SEL_MSB 13
`define DSF_FLAG_LSB 3
`define DSF_FLAG_MSB 7
`define DSF_BIT_HALF_IRQ_EN 0
`define DSF_BIT_CH_ENABLE 0

`define DSF_IDX_HIGH 4
`define DSF_IDX_LOW 3
`define DSF_IDX_DONE 2
`define DSF_IDX_HALF 1
`define DSF_IDX_OVR 0

`define DSF_SFR_END 16'h07ff
`define DSF_RAM_TOP 16'h27ff
`define DSF_UPPER_RST 16'hffff
`define DSF_LOWER_RST 16'h0000

`define DSF_RESP_OKAY 2'h0
`define DSF_RESP_SLVERR 2'h2

`endif

// [shared/dsf_pkg.sv]
// Purpose: shared types of the channel status block
// Assumes: nothing
// Notes: flag vector order is high, low, done, half, overrun (msb first)
package dsf_pkg;
  typedef logic [4:0] dsf_flags_t;
  typedef logic [15:0] dsf_addr_t;
  typedef logic [5:0] dsf_sel_t;
endpackage

// [test/dsf_engine_model.sv]
// Purpose: behavioural transfer engine feeding the status block
// Assumes: at most one command per cycle from the bench
// Notes: cmd 1..7 pulse access, trigger, half, done, abort, load, written
`timescale 1ns/1ps
`default_nettype none
module dsf_engine_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [2:0] cmd_in,
  input wire logic [15:0] addr_in,
  output logic [6:0] ev_out,
  output logic [15:0] addr_out,
  output logic busy_out
);
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ev_out <= 7'h00;
      busy_out <= 1'b0;
      addr_out <= 16'h0000;
    end else begin
      ev_out <= (cmd_in == 3'h0) ? 7'h00 : 7'h01 << (cmd_in - 3'h1);
      // busy lags the trigger so the starting trigger never sees itself busy
      if (ev_out[1]) begin
        busy_out <= 1'b1;
      end else if (ev_out[3] || ev_out[4]) begin
        busy_out <= 1'b0;
      end
      // junk outside a strobe, alternately the inverted and the true last address
      addr_out <= (cmd_in == 3'h1) ? addr_in : ~addr_out;
    end
  end
endmodule
`default_nettype wire

// [test/dsf_status_top_tb.sv]
// Purpose: register-level bench for the channel status block
// Assumes: engine events come from dsf_engine_model
// Notes: each event except abort, load and written is followed by reads of INT and PEND and a clear
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.svh"
module dsf_status_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, channel_enable, busy;
  logic [1:0] bresp, rresp;
  logic [5:0] sel;
  logic [2:0] cmd = 3'h0;
  logic [15:0] cmd_addr = 16'h0, eaddr, base;
  logic [6:0] ev_p;
  logic [15:0] at [6] = '{16'h2000, 16'h2001, 16'h1000, 16'h0fff, 16'h0800, 16'h07ff};
  logic [15:0] fl [6] = '{16'h00, 16'h80, 16'h00, 16'h40, 16'h40, 16'h00};
  int n_mismatch = 0, checked = 0;
  dsf_status_top u_dut (.core_clk_in(clk), .reset_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .access_valid_in(ev_p[0]), .access_addr_in(eaddr),
    .trigger_in(ev_p[1]), .busy_in(busy), .half_in(ev_p[2]), .done_in(ev_p[3]),
    .abort_in(ev_p[4]), .buf_load_in(ev_p[5]), .buf_written_in(ev_p[6]),
    .channel_enable_out(channel_enable), .trigger_source_select_out(sel), .irq_out(irq));
  dsf_engine_model u_eng (.core_clk_in(clk), .reset_in(rst), .cmd_in(cmd),
    .addr_in(cmd_addr), .ev_out(ev_p), .addr_out(eaddr), .busy_out(busy));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic lim(input int n);
    if (n >= 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    lim(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    lim(n);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic ev(input logic [2:0] c, input logic [15:0] a);
    @(posedge clk);
    cmd <= c;
    cmd_addr <= a;
    @(posedge clk);
    cmd <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  // checks irq, flags and pending, then clears both for the next case
  task automatic st(input logic [15:0] fi, input logic [15:0] fp, input logic ei);
    chk({31'h0, irq}, {31'h0, ei});
    rd(`DSF_OFF_INT, {16'h0, base | fi});
    rd(`DSF_OFF_PEND, {16'h0, fp});
    wr(`DSF_OFF_PEND, 32'hf8);
    wr(`DSF_OFF_INT, {16'h0, base});
  endtask
  initial begin
    base = 16'h2a01;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`DSF_OFF_INT, 32'h0);
    rd(`DSF_OFF_PEND, 32'h0);
    rd(`DSF_OFF_UPPER, 32'hffff);
    rd(`DSF_OFF_LOWER, 32'h0);
    rd(`DSF_OFF_CTRL, 32'h0);
    rd(8'h18, 32'h0, `DSF_RESP_SLVERR);
    wr(8'h18, 32'hffff, `DSF_RESP_SLVERR);
    wr(`DSF_OFF_CTRL, 32'h1);
    chk({31'h0, channel_enable}, 32'h1);
    wr(`DSF_OFF_INT, {16'h0, base});
    chk({26'h0, sel}, 32'h2a);
    wr(`DSF_OFF_MASK, 32'hf8);
    rd(`DSF_OFF_MASK, 32'hf8);
    ev(3'h1, 16'h27ff);
    st(16'h0, 16'h0, 1'b0);
    ev(3'h1, 16'h2800);
    st(16'h80, 16'h80, 1'b1);
    wr(`DSF_OFF_UPPER, 32'h2000);
    wr(`DSF_OFF_LOWER, 32'h1000);
    for (int i = 0; i < 6; i++) begin
      ev(3'h1, at[i]);
      st(fl[i], fl[i], fl[i] != 16'h0);
    end
    ev(3'h2, 16'h0);
    st(16'h0, 16'h0, 1'b0);
    ev(3'h2, 16'h0);
    st(16'h08, 16'h08, 1'b1);
    ev(3'h4, 16'h0);
    st(16'h20, 16'h20, 1'b1);
    wr(`DSF_OFF_INT, {16'h0, base | 16'h00f8});
    rd(`DSF_OFF_PEND, 32'h0);
    chk({31'h0, irq}, 32'h0);
    ev(3'h5, 16'h0);
    rd(`DSF_OFF_INT, {16'h0, base | 16'h00d8});
    wr(`DSF_OFF_INT, {16'h0, base});
    ev(3'h3, 16'h0);
    st(16'h10, 16'h10, 1'b1);
    base = 16'h2a00;
    wr(`DSF_OFF_INT, {16'h0, base});
    ev(3'h3, 16'h0);
    st(16'h10, 16'h0, 1'b0);
    ev(3'h4, 16'h0);
    st(16'h20, 16'h20, 1'b1);
    ev(3'h6, 16'h0);
    rd(`DSF_OFF_INT, {16'h0, base | 16'h8000});
    ev(3'h7, 16'h0);
    rd(`DSF_OFF_INT, {16'h0, base});
    wr(`DSF_OFF_MASK, 32'h0);
    ev(3'h1, 16'h2001);
    st(16'h80, 16'h80, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
